/* bench/tiwsc_cpu_model.sv */
// Core-side partner: interrupt acknowledge and opcode issue
`timescale 1ns/1ps
module tiwsc_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Interrupt handshake, ack ack_dly+1 cycles after int_req is first seen
  input  wire logic       int_req,
  input  wire logic [3:0] ack_dly,
  output logic            int_ack,
  // Opcode requests from the bench
  input  wire logic       op_go,
  input  wire logic [7:0] op_sel,
  output logic            op_valid,
  output logic [7:0]      op_code
);
  logic [3:0] wait_q;
  logic       sleep_q;

  // Slow settings mimic a core busy finishing an instruction
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_q  <= 4'h0;
      int_ack <= 1'b0;
    end
    else if (!int_req || int_ack)
    begin
      wait_q  <= 4'h0;
      int_ack <= 1'b0;
    end
    else if (wait_q == ack_dly)
      int_ack <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end

  // Sleep opcodes go out behind a pipeline-flushing no-op
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_valid <= 1'b0;
      op_code  <= 8'h00;
      sleep_q  <= 1'b0;
    end
    else if (op_go)
    begin
      op_valid <= 1'b1;
      sleep_q  <= (op_sel == 8'h6f) || (op_sel == 8'h7f);
      op_code  <= ((op_sel == 8'h6f) || (op_sel == 8'h7f)) ? 8'hff : op_sel;
    end
    else if (sleep_q)
    begin
      op_valid <= 1'b1;
      op_code  <= op_sel;
      sleep_q  <= 1'b0;
    end
    else
    begin
      op_valid <= 1'b0;
      op_code  <= ~op_code; // Idle code bus alternates the stale opcode with its complement
    end
  end
endmodule : tiwsc_cpu_model

/* bench/tiwsc_ctrl_tb_top.sv */
// Bench top: registers, timer, interrupts, sleep and watchdog
`timescale 1ns/1ps
module tiwsc_ctrl_tb_top;
  import tiwsc_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, op_valid, op_go = 1'b0, int_ack, int_req, int_grant;
  logic [7:0]  op_code, op_sel = 8'h00;
  logic [8:0]  int_vec_addr;
  logic [2:0]  flag_zsv;
  logic [15:0] restart_pc;
  logic [3:0]  ack_dly = 4'h0;
  logic        flag_upd, cpu_clk_en, osc_en, cpu_rst, port_mode_keep, rc_tick = 1'b0;
  logic        line1 = 1'b1, line2 = 1'b1, line3 = 1'b1, srp = 1'b1, perm = 1'b0;
  logic [4:0]  ev;
  int          num_errors = 0, num_checks = 0, cyc = 0, n;

  // Short watchdog and power-on counts keep the run brief
  tiwsc_ctrl #(.WDT_TICKS(4), .POR_TICKS(2)) uut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .op_valid(op_valid), .op_code(op_code),
    .int_ack(int_ack), .int_req(int_req), .int_grant(int_grant),
    .int_vec_addr(int_vec_addr), .flag_upd(flag_upd), .flag_zsv(flag_zsv),
    .cpu_clk_en(cpu_clk_en), .osc_en(osc_en), .cpu_rst(cpu_rst), .restart_pc(restart_pc),
    .port_mode_keep(port_mode_keep), .port3_line1(line1), .port3_line2(line2),
    .port3_line3(line3), .stop_recovery_pin(srp), .rc_tick(rc_tick), .perm_wdt_opt(perm));

  tiwsc_cpu_model cpu (
    .clk(clk), .sys_rst(sys_rst), .int_req(int_req), .ack_dly(ack_dly),
    .int_ack(int_ack), .op_go(op_go), .op_sel(op_sel), .op_valid(op_valid),
    .op_code(op_code));

  // Watched outputs, indexed by the wait task
  assign ev = {flag_upd, int_grant, cpu_rst, osc_en, cpu_clk_en};

  always #5 clk = ~clk;

  // RC timebase every 8 clocks; cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rc_tick <= (cyc % 8 == 7);
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask : rd

  // Reads until all bits of m are set, bounded
  task automatic poll(input logic [4:0] a, input logic [31:0] m);
    q = 32'h0;
    for (int k = 0; k < 30 && (q & m) !== m; k++)
      bus(1'b0, a, 32'h0);
  endtask : poll

  task automatic op(input logic [7:0] c);
    op_sel <= c;
    op_go <= 1'b1;
    @(posedge clk);
    op_go <= 1'b0;
    @(posedge clk);
  endtask : op

  task automatic till(input int i, input logic v);
    n = 0;
    while (ev[i] !== v && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 600)
      num_errors++;
  endtask : till

  task automatic close_out();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    till(2, 1'b0);
    chk("cpu_rst", 32'h0, cpu_rst);
    chk("restart_pc", 32'h000c, restart_pc);
    rd(5'h1c, 32'h0, "unmapped");
    bus(1'b1, OFS_PRE, 32'h3);
    rd(OFS_PRE, 32'h0, "prescaler");
    bus(1'b1, OFS_PRE, 32'h1);
    bus(1'b1, OFS_TCNT, 32'h3);
    bus(1'b1, OFS_TCTL, 32'h3);
    poll(OFS_IPEND, 32'h20);
    chk("pending timer", 32'h20, q);
    rd(OFS_TCNT, 32'h0, "count");
    bus(1'b1, OFS_TCTL, 32'h7);
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, OFS_IPEND, 32'h3f);
      poll(OFS_IPEND, 32'h20);
      chk("pending reload", 32'h20, q);
    end
    bus(1'b1, OFS_TCTL, 32'h0);
    bus(1'b1, OFS_IPEND, 32'h3f);
    repeat (30) @(posedge clk);
    rd(OFS_IPEND, 32'h0, "pending stopped");
    bus(1'b1, OFS_TCTL, 32'h0b);
    for (int k = 0; k < 3; k++)
    begin
      line1 <= 1'b0;
      repeat (2) @(posedge clk);
      line1 <= 1'b1;
      repeat (2) @(posedge clk);
    end
    rd(OFS_IPEND, 32'h24, "pending ext clock");
    bus(1'b1, OFS_IPEND, 32'h3f);
    bus(1'b1, OFS_IPRIO, 32'h1);
    line2 <= 1'b0;
    line3 <= 1'b0;
    poll(OFS_IPEND, 32'h3);
    chk("pending masked", 32'h3, q);
    ack_dly <= 4'h3;
    bus(1'b1, OFS_IMASK, 32'h83);
    till(3, 1'b1);
    chk("vector", 32'h2, int_vec_addr);
    chk("int_req granted", 32'h0, int_req);
    rd(OFS_IMASK, 32'h3, "mask");
    ack_dly <= 4'h0;
    bus(1'b1, OFS_IMASK, 32'h83);
    till(3, 1'b1);
    chk("vector", 32'h0, int_vec_addr);
    line2 <= 1'b1;
    poll(OFS_IPEND, 32'h8);
    chk("pending rise", 32'h8, q);
    bus(1'b1, OFS_IPEND, 32'h3f);
    bus(1'b1, OFS_IMASK, 32'h84);
    ack_dly <= 4'h8;
    op(OP_HALT);
    till(0, 1'b0);
    chk("clk_en halt", 32'h0, cpu_clk_en);
    line1 <= 1'b0;
    till(0, 1'b1);
    chk("clk_en wake", 32'h1, cpu_clk_en);
    till(3, 1'b1);
    chk("vector", 32'h4, int_vec_addr);
    op(OP_STOP);
    till(1, 1'b0);
    chk("osc_en stop", 32'h0, osc_en);
    srp <= 1'b0;
    till(2, 1'b1);
    chk("cpu_rst recover", 32'h1, cpu_rst);
    srp <= 1'b1;
    till(2, 1'b0);
    chk("port_mode_keep", 32'h1, port_mode_keep);
    op(OP_WD_HALT);
    rd(OFS_STAT, 32'h20, "status");
    op(OP_WD_REFR);
    till(4, 1'b1);
    chk("flags", 32'h4, flag_zsv);
    rd(OFS_STAT, 32'h24, "status");
    op(OP_WD_HALT);
    rd(OFS_STAT, 32'h2c, "status");
    for (int k = 0; k < 3; k++)
    begin
      repeat (10) @(posedge clk);
      op(OP_WD_REFR);
      chk("cpu_rst refreshed", 32'h0, cpu_rst);
    end
    till(2, 1'b1);
    chk("cpu_rst timeout", 32'h1, cpu_rst);
    till(2, 1'b0);
    chk("port_mode_keep", 32'h0, port_mode_keep);
    rd(OFS_STAT, 32'h0, "status");
    perm <= 1'b1;
    repeat (2) @(posedge clk);
    rd(OFS_STAT, 32'h14, "status perm");
    close_out();
  end
endmodule : tiwsc_ctrl_tb_top

/* logic/tiwsc_ctrl.sv */
// Timer, vectored interrupts, watchdog and sleep control for a small core
// Operation
// (RULE_01) Prescaler divides timer source by 1..64
// (RULE_02) Counter counts 1..256, end raises timer source
// (RULE_03) Single-pass stops at zero, modulo-N reloads
// (RULE_04) Start, stop, resume or restart the counter
// (RULE_05) Counter readable undisturbed, prescaler not readable
// (RULE_06) Source is clock over four or pin
// (RULE_07) Pin is clock, retrigger, one-shot trigger, gate
// (RULE_08) Three falling edges, one rising, timer
// (RULE_09) Source n vectors through bytes 2n, 2n+1
// (RULE_10) Per-source masks plus one global enable
// (RULE_11) Programmable priority picks among pending requests
// (RULE_12) Grant disables interrupts, saves context, branches
// (RULE_13) Masked requests still latch for polling
// (RULE_14) Halt stops core, enabled interrupt wakes
// (RULE_15) Stop released by low level, restart 000C
// (RULE_16) Stop recovery keeps port mode registers
// (RULE_17) Software issues no-op before stop or halt
// (RULE_18) First refresh enables watchdog, later ones clear
// (RULE_19) Refresh sets zero, clears sign and overflow
// (RULE_20) Timeout gives power-on reset plus 18 cycles
// (RULE_21) Watchdog idle in stop and halt unless allowed
// (RULE_22) Halt-run opcode needs enabled watchdog, keeps count
// (RULE_23) Watchdog counts ticks of its own oscillator
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module tiwsc_ctrl #(
  parameter int WDT_TICKS = tiwsc_pkg::WDT_TICKS_DEF,
  parameter int POR_TICKS = tiwsc_pkg::POR_TICKS_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM register slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // CPU opcode and interrupt handshake
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_code,
  input  wire logic        int_ack,
  output logic             int_req,
  output logic             int_grant,
  output logic      [8:0]  int_vec_addr,
  output logic             flag_upd,
  output logic      [2:0]  flag_zsv,
  // Clock, reset and restart control
  output logic             cpu_clk_en,
  output logic             osc_en,
  output logic             cpu_rst,
  output logic      [15:0] restart_pc,
  output logic             port_mode_keep,
  // Pins and options
  input  wire logic        port3_line1,
  input  wire logic        port3_line2,
  input  wire logic        port3_line3,
  input  wire logic        stop_recovery_pin,
  input  wire logic        rc_tick,
  input  wire logic        perm_wdt_opt
);
  import tiwsc_pkg::*;

  logic        wait_q;
  logic [31:0] rdata_q;
  logic [7:0]  tctl_q;
  logic [7:0]  init_q;
  logic [7:0]  cnt_q;
  logic [5:0]  pre_q;
  logic [5:0]  pre_cnt_q;
  logic        trig_q;
  logic [1:0]  div_q;
  logic [2:0]  pin_q;
  logic [5:0]  pend_q;
  logic [5:0]  mask_q;
  logic        gie_q;
  logic [2:0]  prio_q;
  logic        halt_q;
  logic        stop_q;
  logic        wd_en_q;
  logic        wdh_q;
  logic        perm_q;
  logic [15:0] wd_cnt_q;
  logic [15:0] rs_cnt_q;
  tiwsc_rst_t  rs_q;
  logic        int_req_q;
  logic        int_grant_q;
  logic [8:0]  vec_q;
  logic        flag_upd_q;
  logic [2:0]  flag_zsv_q;
  logic        cpu_clk_en_q;
  logic        osc_en_q;
  logic        cpu_rst_q;
  logic        keep_q;

  // Bus strobes: a write lands only in the cycle waitrequest is low
  logic wr_go;
  logic rd_go;
  assign wr_go = avs_write && !wait_q;
  assign rd_go = avs_read && !wait_q;

  // Opcode strobes; the core is expected to retire a no-op first (RULE_17)
  logic op_stop;
  logic op_halt;
  logic op_refr;
  logic op_wdh;
  assign op_stop = op_valid && (op_code == OP_STOP);
  assign op_halt = op_valid && (op_code == OP_HALT);
  assign op_refr = op_valid && (op_code == OP_WD_REFR);
  assign op_wdh  = op_valid && (op_code == OP_WD_HALT);

  // Watchdog timeout wipes block state just like power-on
  logic wd_to;
  logic soft_clr;
  assign soft_clr = wd_to;

  // Single-cycle wait state; read data registered ahead of the release
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wait_q <= 1'b1;
    else if ((avs_read || avs_write) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // Read mux; prescaler and unmapped offsets read zero (RULE_05)
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 32'h0;
    else if (avs_read && wait_q)
    begin
      case (avs_address)
        OFS_TCTL:  rdata_q <= {24'h0, tctl_q};
        OFS_TCNT:  rdata_q <= {24'h0, cnt_q}; // RULE_05
        OFS_IPEND: rdata_q <= {26'h0, pend_q};
        OFS_IMASK: rdata_q <= {24'h0, gie_q, 1'b0, mask_q};
        OFS_IPRIO: rdata_q <= {29'h0, prio_q};
        OFS_STAT:  rdata_q <= {26'h0, keep_q, perm_q, wdh_q, wd_en_q, stop_q, halt_q};
        default:   rdata_q <= 32'h0;
      endcase
    end
  end

  // Internal clock over four and pin edge detect (RULE_06)
  logic int_tick;
  logic ln1_fall;
  assign int_tick = (div_q == 2'(INT_DIV - 1)) && !stop_q;
  assign ln1_fall = pin_q[0] && !port3_line1;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q <= 2'h0;
      pin_q <= 3'h7;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      pin_q <= {port3_line3, port3_line2, port3_line1};
    end
  end

  // Timer source selection per external-input use (RULE_07)
  tiwsc_ext_t ext_mode;
  logic       trig_mode;
  logic       src_tick;
  logic       pre_end;
  logic       eoc;
  logic       tload;
  assign ext_mode  = tiwsc_ext_t'(tctl_q[TCTL_MODE_L +: 2]);
  assign trig_mode = tctl_q[TCTL_EXT] &&
                     (ext_mode == TIWSC_TRIG_RE || ext_mode == TIWSC_TRIG_NR);
  always_comb
  begin
    src_tick = int_tick; // RULE_06
    if (tctl_q[TCTL_EXT])
    begin
      case (ext_mode)
        TIWSC_EXT_CLOCK: src_tick = ln1_fall && !stop_q; // RULE_07
        TIWSC_GATE:      src_tick = int_tick && port3_line1; // RULE_07
        default:         src_tick = int_tick && trig_q; // RULE_07
      endcase
    end
  end
  // Ratio 0 wraps to 63 in six bits, so it divides by 64
  assign pre_end = src_tick && tctl_q[TCTL_RUN] &&
                   (pre_cnt_q == pre_q - 6'h1); // RULE_01
  assign eoc     = pre_end && (cnt_q == 8'h01); // RULE_02
  assign tload   = wr_go && (avs_address == OFS_TCTL) && avs_writedata[TCTL_LOAD];

  // Trigger arming: retrigger restarts, one-shot ignores while armed
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      trig_q <= 1'b0;
    else if (soft_clr || !trig_mode)
      trig_q <= 1'b0;
    else if (ln1_fall)
      trig_q <= 1'b1; // RULE_07
    else if (eoc && !tctl_q[TCTL_MODULO])
      trig_q <= 1'b0;
  end

  // Timer control; a single pass drops the run bit itself (RULE_04)
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tctl_q <= 8'h00;
    else if (soft_clr)
      tctl_q <= 8'h00;
    else if (wr_go && avs_address == OFS_TCTL)
      tctl_q <= {2'b00, avs_writedata[5:1], 1'b0}; // RULE_04
    else if (eoc && !tctl_q[TCTL_MODULO])
      tctl_q[TCTL_RUN] <= 1'b0; // RULE_03
  end

  // Initial value and prescaler ratio, both write side only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      init_q <= TCNT_RST;
      pre_q  <= PRE_RST;
    end
    else if (soft_clr)
    begin
      init_q <= TCNT_RST;
      pre_q  <= PRE_RST;
    end
    else if (wr_go && avs_address == OFS_TCNT)
      init_q <= avs_writedata[7:0];
    else if (wr_go && avs_address == OFS_PRE)
      pre_q <= avs_writedata[5:0]; // RULE_01
  end

  // Prescaler and down-counter; retrigger also restarts the count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_cnt_q <= 6'h0;
      cnt_q     <= TCNT_RST;
    end
    else if (soft_clr)
    begin
      pre_cnt_q <= 6'h0;
      cnt_q     <= TCNT_RST;
    end
    else if (tload || (trig_mode && ln1_fall &&
             (ext_mode == TIWSC_TRIG_RE || !trig_q)))
    begin
      pre_cnt_q <= 6'h0;
      cnt_q     <= init_q; // RULE_04
    end
    else if (pre_end)
    begin
      pre_cnt_q <= 6'h0;
      if (eoc)
        cnt_q <= tctl_q[TCTL_MODULO] ? init_q : 8'h00; // RULE_03
      else
        cnt_q <= cnt_q - 8'h01; // RULE_02
    end
    else if (src_tick && tctl_q[TCTL_RUN])
      pre_cnt_q <= pre_cnt_q + 6'h1; // RULE_01
  end

  // Source events: masks do not gate latching (RULE_13)
  logic [5:0] ev;
  assign ev[SRC_AN2_FALL] = pin_q[1] && !port3_line2; // RULE_08
  assign ev[SRC_REF_FALL] = pin_q[2] && !port3_line3; // RULE_08
  assign ev[SRC_AN1_FALL] = ln1_fall; // RULE_08
  assign ev[SRC_AN2_RISE] = !pin_q[1] && port3_line2; // RULE_08
  assign ev[SRC_RESERVED] = 1'b0;
  assign ev[SRC_TIMER]    = eoc; // RULE_02

  // Priority: chosen source highest, then counting down with wrap
  function automatic logic [2:0] pick(input logic [5:0] req, input logic [2:0] top);
    logic [2:0] idx;
    pick = 3'h7;
    for (int k = NUM_SRC - 1; k >= 0; k--)
    begin
      idx = 3'((int'(top) + NUM_SRC - k) % NUM_SRC);
      if (req[idx])
        pick = idx;
    end
  endfunction : pick

  logic [5:0] live;
  logic [2:0] win;
  logic       take;
  assign live = pend_q & mask_q; // RULE_10
  assign win  = pick(live, prio_q); // RULE_11
  assign take = int_req_q && int_ack;

  // Pending bits: write one to clear; a new event beats the clear
  generate
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_pend
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          pend_q[g] <= 1'b0;
        else if (soft_clr)
          pend_q[g] <= 1'b0;
        else if (ev[g])
          pend_q[g] <= 1'b1; // RULE_13
        else if ((take && win == 3'(g)) ||
                 (wr_go && avs_address == OFS_IPEND && avs_writedata[g]))
          pend_q[g] <= 1'b0;
      end
    end
  endgenerate

  // Mask, global enable and priority; grant turns global enable off
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_q <= IMASK_RST;
      gie_q  <= 1'b0;
      prio_q <= IPRIO_RST;
    end
    else if (soft_clr)
    begin
      mask_q <= IMASK_RST;
      gie_q  <= 1'b0;
      prio_q <= IPRIO_RST;
    end
    else if (take)
      gie_q <= 1'b0; // RULE_12
    else if (wr_go && avs_address == OFS_IMASK)
    begin
      mask_q <= avs_writedata[5:0]; // RULE_10
      gie_q  <= avs_writedata[IMASK_GIE]; // RULE_10
    end
    else if (wr_go && avs_address == OFS_IPRIO)
      prio_q <= avs_writedata[2:0]; // RULE_11
  end

  // Request, grant pulse and vector byte address
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_req_q   <= 1'b0;
      int_grant_q <= 1'b0;
      vec_q       <= 9'h0;
    end
    else
    begin
      int_req_q   <= gie_q && (|live) && !take && !int_grant_q && !stop_q;
      int_grant_q <= take; // RULE_12
      if (take)
        vec_q <= {5'h0, win, 1'b0}; // RULE_09
    end
  end

  // Sleep control: halt wakes on enabled request, stop on low pin
  logic stop_rel;
  assign stop_rel = stop_q && !stop_recovery_pin; // RULE_15
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      halt_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else if (soft_clr || stop_rel)
    begin
      halt_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else if (op_stop)
      stop_q <= 1'b1; // RULE_15
    else if (op_halt)
      halt_q <= 1'b1; // RULE_14
    else if (halt_q && gie_q && (|live))
      halt_q <= 1'b0; // RULE_14
  end

  // Core clock off in halt and stop, oscillator off only in stop
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpu_clk_en_q <= 1'b0;
      osc_en_q     <= 1'b1;
    end
    else
    begin
      cpu_clk_en_q <= !halt_q && !stop_q && !op_halt && !op_stop; // RULE_14
      osc_en_q     <= !stop_q && !op_stop; // RULE_15
    end
  end

  // Watchdog enable, halt-run latch and sampled permanent option
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wd_en_q <= 1'b0;
      wdh_q   <= 1'b0;
      perm_q  <= 1'b0;
    end
    else
    begin
      perm_q <= perm_wdt_opt;
      if (soft_clr)
      begin
        wd_en_q <= 1'b0;
        wdh_q   <= 1'b0;
      end
      else
      begin
        if (op_refr || perm_q)
          wd_en_q <= 1'b1; // RULE_18
        if (op_wdh && wd_en_q)
          wdh_q <= 1'b1; // RULE_22
      end
    end
  end

  // Watchdog counts oscillator ticks only where allowed to run
  logic wd_run;
  assign wd_run = wd_en_q && (!halt_q || wdh_q || perm_q) && (!stop_q || perm_q); // RULE_21
  assign wd_to  = wd_run && rc_tick && (wd_cnt_q == 16'(WDT_TICKS - 1)); // RULE_20
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wd_cnt_q <= 16'h0;
    else if (op_refr || wd_to || !wd_en_q)
      wd_cnt_q <= 16'h0; // RULE_18
    else if (wd_run && rc_tick)
      wd_cnt_q <= wd_cnt_q + 16'h1; // RULE_23
  end

  // Refresh reports Z=1, S=0, V=0 to the core
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag_upd_q <= 1'b0;
      flag_zsv_q <= 3'h0;
    end
    else
    begin
      flag_upd_q <= op_refr; // RULE_19
      flag_zsv_q <= op_refr ? FLAGS_ZSV : 3'h0; // RULE_19
    end
  end

  // Reset sequencer: oscillator delay, then 18 clock tail
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rs_q     <= TIWSC_RS_POR;
      rs_cnt_q <= 16'h0;
      keep_q   <= 1'b0;
    end
    else if (wd_to || stop_rel)
    begin
      rs_q     <= TIWSC_RS_POR; // RULE_20
      rs_cnt_q <= 16'h0;
      keep_q   <= stop_rel; // RULE_16
    end
    else
    begin
      case (rs_q)
        TIWSC_RS_POR:
        begin
          if (rc_tick && rs_cnt_q == 16'(POR_TICKS - 1))
          begin
            rs_q     <= TIWSC_RS_TAIL;
            rs_cnt_q <= 16'h0;
          end
          else if (rc_tick)
            rs_cnt_q <= rs_cnt_q + 16'h1;
        end
        TIWSC_RS_TAIL:
        begin
          if (rs_cnt_q == 16'(XTAL_TAIL_CYC - 1))
            rs_q <= TIWSC_RS_IDLE; // RULE_20
          else
            rs_cnt_q <= rs_cnt_q + 16'h1;
        end
        default:
          rs_cnt_q <= 16'h0;
      endcase
    end
  end

  // Core reset level follows the sequencer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cpu_rst_q <= 1'b1;
    else
      cpu_rst_q <= wd_to || stop_rel || (rs_q != TIWSC_RS_IDLE &&
                   !(rs_q == TIWSC_RS_TAIL && rs_cnt_q == 16'(XTAL_TAIL_CYC - 1)));
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign int_req         = int_req_q;
  assign int_grant       = int_grant_q;
  assign int_vec_addr    = vec_q;
  assign flag_upd        = flag_upd_q;
  assign flag_zsv        = flag_zsv_q;
  assign cpu_clk_en      = cpu_clk_en_q;
  assign osc_en          = osc_en_q;
  assign cpu_rst         = cpu_rst_q;
  assign restart_pc      = RESTART_PC; // RULE_15
  assign port_mode_keep  = keep_q;

  // Checks
  sequence s_enter_halt;
    op_halt && !soft_clr && !stop_rel && !op_stop;
  endsequence
  sequence s_clock_off;
    !cpu_clk_en_q ##1 !cpu_clk_en_q;
  endsequence

  chk_timer_event: assert property (@(posedge clk) disable iff (sys_rst)
    eoc && !soft_clr |=> pend_q[SRC_TIMER]) // RULE_02
    else $error("timer end did not latch request");
  chk_single_stop: assert property (@(posedge clk) disable iff (sys_rst)
    eoc && !tctl_q[TCTL_MODULO] && !tload && !soft_clr && !wr_go && !ln1_fall
    |=> cnt_q == 8'h00 && !tctl_q[TCTL_RUN]) // RULE_03
    else $error("single pass did not stop at zero");
  chk_modulo_load: assert property (@(posedge clk) disable iff (sys_rst)
    eoc && tctl_q[TCTL_MODULO] && !tload && !soft_clr && !ln1_fall
    |=> cnt_q == $past(init_q)) // RULE_03
    else $error("modulo count did not reload");
  chk_masked_latch: assert property (@(posedge clk) disable iff (sys_rst)
    ev[SRC_AN2_FALL] && !mask_q[SRC_AN2_FALL] && !soft_clr
    |=> pend_q[SRC_AN2_FALL]) // RULE_13
    else $error("masked event was lost");
  chk_grant_vector: assert property (@(posedge clk) disable iff (sys_rst)
    take && !soft_clr |=> int_grant_q && !gie_q && vec_q == {5'h0, $past(win), 1'b0}) // RULE_12
    else $error("grant did not disable or vector");
  chk_halt_clock: assert property (@(posedge clk) disable iff (sys_rst)
    s_enter_halt ##1 (halt_q && !(gie_q && |live)) |-> s_clock_off) // RULE_14
    else $error("core clock ran during halt");
  chk_stop_release: assert property (@(posedge clk) disable iff (sys_rst)
    stop_rel |=> !stop_q && cpu_rst_q && keep_q) // RULE_15
    else $error("stop not released on low pin");
  chk_refresh_flags: assert property (@(posedge clk) disable iff (sys_rst)
    op_refr |=> flag_upd_q && flag_zsv_q == 3'b100) // RULE_19
    else $error("refresh flags wrong");
  chk_wdh_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    op_wdh && !wd_en_q && !wdh_q |=> !wdh_q) // RULE_22
    else $error("halt-run opcode acted without enable");
  chk_wd_reset: assert property (@(posedge clk) disable iff (sys_rst)
    wd_to |=> cpu_rst_q && rs_q == TIWSC_RS_POR && !wd_en_q) // RULE_20
    else $error("watchdog timeout gave no reset");
  chk_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle");
endmodule : tiwsc_ctrl

/* logic/tiwsc_pkg.sv */
// Shared constants for the timer, interrupt, watchdog and sleep control block
package tiwsc_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_TCTL   = 5'h00;
  localparam logic [4:0] OFS_TCNT   = 5'h04;
  localparam logic [4:0] OFS_PRE    = 5'h08;
  localparam logic [4:0] OFS_IPEND  = 5'h0c;
  localparam logic [4:0] OFS_IMASK  = 5'h10;
  localparam logic [4:0] OFS_IPRIO  = 5'h14;
  localparam logic [4:0] OFS_STAT   = 5'h18;
  // Timer control fields and the global enable bit of the mask register
  localparam int TCTL_LOAD   = 0;
  localparam int TCTL_RUN    = 1;
  localparam int TCTL_MODULO = 2;
  localparam int TCTL_EXT    = 3;
  localparam int TCTL_MODE_L = 4;
  localparam int IMASK_GIE   = 7;
  // Reset values
  localparam logic [7:0] TCNT_RST  = 8'h00;
  localparam logic [5:0] PRE_RST   = 6'h00;
  localparam logic [5:0] IMASK_RST = 6'h00;
  localparam logic [2:0] IPRIO_RST = 3'h0;
  // Interrupt sources
  localparam int NUM_SRC       = 6;
  localparam int SRC_AN2_FALL  = 0;
  localparam int SRC_REF_FALL  = 1;
  localparam int SRC_AN1_FALL  = 2;
  localparam int SRC_AN2_RISE  = 3;
  localparam int SRC_RESERVED  = 4;
  localparam int SRC_TIMER     = 5;
  // Opcodes watched on the CPU side, restart address and refresh flags
  localparam logic [7:0] OP_STOP     = 8'h6f;
  localparam logic [7:0] OP_HALT     = 8'h7f;
  localparam logic [7:0] OP_WD_REFR  = 8'h5f;
  localparam logic [7:0] OP_WD_HALT  = 8'h4f;
  localparam logic [15:0] RESTART_PC = 16'h000c;
  localparam logic [2:0] FLAGS_ZSV   = 3'b100;
  // Timing
  localparam int CLK_MHZ         = 100;
  localparam int INT_DIV         = 4;
  localparam int XTAL_TAIL_CYC   = 18;
  localparam int WDT_TICKS_DEF   = 256;
  localparam int POR_TICKS_DEF   = 64;
  // Timer external-input uses
  typedef enum logic [1:0] {
    TIWSC_EXT_CLOCK = 2'b00,
    TIWSC_TRIG_RE   = 2'b01,
    TIWSC_TRIG_NR   = 2'b10,
    TIWSC_GATE      = 2'b11
  } tiwsc_ext_t;
  // Reset sequencer
  typedef enum logic [1:0] {
    TIWSC_RS_IDLE = 2'b00,
    TIWSC_RS_POR  = 2'b01,
    TIWSC_RS_TAIL = 2'b10
  } tiwsc_rst_t;
endpackage : tiwsc_pkg
